// File: hw/pio_pkg.sv
// Constants and carrier types for the port configuration register bank.
// Assumes the core presents one SFR access per cycle on a single clock.
//----------------------------------------------------------------------
// Functional notes
// R1 - Written port data value is held in the output latch until rewritten.
// R2 - Ordinary data register reads return the synchronised pin levels.
// R3 - Read-modify-write reads return the latch instead of the pins.
// R4 - All registers take byte access; data registers also take bit access.
// R5 - First port data register sits at 0x80, all pages, bit addressable, 8 pins.
// R6 - Second port data register sits at 0x90 and behaves like the first.
// R7 - A set bypass bit makes the crossbar pass over that pin.
// R8 - Software should bypass analog, plain GPIO and dedicated digital pins.
// R9 - Analog select 0 disables pullup, driver and receiver; 1 selects digital.
// R10 - Software sets analog or digital itself even for crossbar pins.
// R11 - The fifth pin of port two is always digital.
// R12 - Driver type bit 0 gives open-drain, 1 gives push-pull.
// R13 - Driver type is ignored while the pin is in analog mode.
// R14 - Pins carrying SMBus data and clock always drive open-drain.
// R15 - Reset sets latches high, pins digital open-drain, none bypassed.
//----------------------------------------------------------------------
package pio_pkg;
    localparam int          PIO_W            = 8;
    localparam logic [7:0]  PIO_ADR_DATA0    = 8'h80;
    localparam logic [7:0]  PIO_ADR_DATA1    = 8'h90;
    localparam logic [7:0]  PIO_ADR_DRV0     = 8'hA4;
    localparam logic [7:0]  PIO_ADR_BYP0     = 8'hD4;
    localparam logic [7:0]  PIO_ADR_ANA0     = 8'hF1;
    localparam logic [7:0]  PIO_RST_DATA     = 8'hFF;
    localparam logic [7:0]  PIO_RST_DRV      = 8'h00;
    localparam logic [7:0]  PIO_RST_BYP      = 8'h00;
    localparam logic [7:0]  PIO_RST_ANA      = 8'hFF;
    localparam logic [7:0]  PIO_RST_RDATA    = 8'h00;
    localparam int          PIO_BIT_ADR_POS  = 3;     // Bit address: base in [7:3], bit in [2:0]

    // Request from the core SFR bus
    typedef struct packed {
        logic       wr;     // Write strobe
        logic       rd;     // Read strobe
        logic       rmw;    // Read belongs to a read-modify-write
        logic       bit_op; // Bit access; addr is a bit address
        logic [7:0] addr;
        logic [7:0] wdata;  // Bit access uses wdata[0]
    } pio_req_t;

    // Per-pin drive to one port's pad cells
    typedef struct packed {
        logic [7:0] out;    // Value to the pad
        logic [7:0] oe;     // High while the pad is driven
        logic [7:0] dig;    // Receiver and pullup enabled
    } pio_pad_t;
endpackage

// File: hw/pio_sync.sv
// Two-flop synchroniser for a bus of pin levels.
// Assumes pins are asynchronous to REF_CLK; only the second stage reads the first stage.
module pio_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    // Refuse a width the synchroniser cannot serve
    if (W < 1) begin : g_bad_width
        $error("pio_sync needs a width of at least one bit");
    end

    //------------------------------------------------------------------
    // Synchroniser stages
    //------------------------------------------------------------------
    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '1;
            dout     <= '1;
        end else if (ce) begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// File: hw/pio_regs.sv
// Port data latches and pin mode registers on the core SFR bus.
// Assumes one access per cycle; read data is registered one cycle later.
module pio_regs (
    input  wire logic              REF_CLK,
    input  wire logic              SYS_RST,
    input  wire logic              CLK_EN,
    input  wire pio_pkg::pio_req_t SFR_REQ,
    output logic [7:0]             SFR_RDATA,
    output logic                   SFR_RVALID,
    input  wire logic [7:0]        PORT0_PIN_IN,
    input  wire logic [7:0]        PORT1_PIN_IN,
    input  wire logic [7:0]        PORT0_SMB_PIN,
    input  wire logic [7:0]        PORT0_XBAR_EN,
    input  wire logic [7:0]        PORT0_XBAR_OUT,
    output pio_pkg::pio_pad_t      PORT0_PAD,
    output logic [7:0]             PORT1_LATCH,
    output logic [7:0]             PORT0_BYPASS,
    output logic                   DIGITAL_ONLY_PIN_DIG
);
    import pio_pkg::*;

    logic [7:0] data0_reg, data1_reg, drv0_reg, byp0_reg, ana0_reg;
    logic [7:0] data0_next, data1_next, drv0_next, byp0_next, ana0_next;
    logic [7:0] pin0_s, pin1_s;
    logic [7:0] rdata_next;
    pio_pad_t   pad0_next;

    // Bit-address helpers
    function automatic logic bit_hit(input logic [7:0] a, input logic [7:0] base);
        bit_hit = (a[7:PIO_BIT_ADR_POS] == base[7:PIO_BIT_ADR_POS]);
    endfunction

    function automatic logic [7:0] bit_set(input logic [7:0] v, input logic [2:0] n,
                                           input logic b);
        logic [7:0] r;
        r    = v;
        r[n] = b;
        bit_set = r;
    endfunction

    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    pio_sync #(.W(PIO_W)) u_sync0 (
        .clk  (REF_CLK),
        .rst  (SYS_RST),
        .ce   (CLK_EN),
        .din  (PORT0_PIN_IN),
        .dout (pin0_s)
    );
    pio_sync #(.W(PIO_W)) u_sync1 (
        .clk  (REF_CLK),
        .rst  (SYS_RST),
        .ce   (CLK_EN),
        .din  (PORT1_PIN_IN),
        .dout (pin1_s)
    );

    //------------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------------
    wire wr_byte = SFR_REQ.wr & ~SFR_REQ.bit_op;
    wire wr_bit  = SFR_REQ.wr &  SFR_REQ.bit_op;
    wire rd_byte = SFR_REQ.rd & ~SFR_REQ.bit_op;
    wire rd_bit  = SFR_REQ.rd &  SFR_REQ.bit_op;
    wire hit_d0  = (SFR_REQ.addr == PIO_ADR_DATA0);                  // [R5]
    wire hit_d1  = (SFR_REQ.addr == PIO_ADR_DATA1);                  // [R6]
    wire hit_b0  = bit_hit(SFR_REQ.addr, PIO_ADR_DATA0);             // [R4] [R5]
    wire hit_b1  = bit_hit(SFR_REQ.addr, PIO_ADR_DATA1);             // [R4] [R6]
    wire [2:0] bn = SFR_REQ.addr[2:0];
    // Byte-only configuration registers [R4]
    wire hit_drv0 = (SFR_REQ.addr == PIO_ADR_DRV0);
    wire hit_byp0 = (SFR_REQ.addr == PIO_ADR_BYP0);
    wire hit_ana0 = (SFR_REQ.addr == PIO_ADR_ANA0);

    //------------------------------------------------------------------
    // Register next values
    //------------------------------------------------------------------
    // Latches hold the last write; bit writes change only one pin [R1] [R4]
    assign data0_next = (wr_byte && hit_d0) ? SFR_REQ.wdata :
                        (wr_bit && hit_b0) ? bit_set(data0_reg, bn, SFR_REQ.wdata[0]) :
                        data0_reg;
    assign data1_next = (wr_byte && hit_d1) ? SFR_REQ.wdata :
                        (wr_bit && hit_b1) ? bit_set(data1_reg, bn, SFR_REQ.wdata[0]) :
                        data1_reg;
    // Configuration registers take byte writes only
    assign drv0_next  = (wr_byte && hit_drv0) ? SFR_REQ.wdata : drv0_reg;   // [R12]
    assign byp0_next  = (wr_byte && hit_byp0) ? SFR_REQ.wdata : byp0_reg;   // [R7]
    assign ana0_next  = (wr_byte && hit_ana0) ? SFR_REQ.wdata : ana0_reg;   // [R9]

    // Read source: latch on read-modify-write, pins otherwise [R2] [R3]
    wire [7:0] src0 = SFR_REQ.rmw ? data0_reg : pin0_s;
    wire [7:0] src1 = SFR_REQ.rmw ? data1_reg : pin1_s;

    // Read mux; unmapped addresses read zero
    assign rdata_next =
        (rd_byte && hit_d0)                       ? src0 :
        (rd_byte && hit_d1)                       ? src1 :
        (rd_byte && hit_drv0)                     ? drv0_reg :
        (rd_byte && hit_byp0)                     ? byp0_reg :
        (rd_byte && hit_ana0)                     ? ana0_reg :
        (rd_bit && hit_b0)                        ? {7'h00, src0[bn]} :
        (rd_bit && hit_b1)                        ? {7'h00, src1[bn]} :
        PIO_RST_RDATA;

    //------------------------------------------------------------------
    // Pad drive
    //------------------------------------------------------------------
    // Built from next values so a write reaches the pad at the edge it is taken
    // Pin value from crossbar where assigned and not bypassed, else latch [R7]
    wire [7:0] xsel    = PORT0_XBAR_EN & ~byp0_next;
    wire [7:0] out_val = (xsel & PORT0_XBAR_OUT) | (~xsel & data0_next);
    // Push-pull only when digital, driver bit set and not an SMBus pin
    wire [7:0] pp      = ana0_next & drv0_next & ~PORT0_SMB_PIN;    // [R12] [R13] [R14]
    // Open-drain drives low only; analog pins never drive          [R9]
    assign pad0_next.out = out_val;
    assign pad0_next.oe  = ana0_next & (pp | ~out_val);
    assign pad0_next.dig = ana0_next;

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    // Synchronous reset takes priority over the clock enable
    // Reset: latches high, digital, open-drain, nothing bypassed [R15]
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            data0_reg            <= PIO_RST_DATA;
            data1_reg            <= PIO_RST_DATA;
            drv0_reg             <= PIO_RST_DRV;
            byp0_reg             <= PIO_RST_BYP;
            ana0_reg             <= PIO_RST_ANA;
            SFR_RDATA            <= PIO_RST_RDATA;
            SFR_RVALID           <= 1'b0;
            PORT0_PAD.out        <= PIO_RST_DATA;
            PORT0_PAD.oe         <= 8'h00;
            PORT0_PAD.dig        <= PIO_RST_ANA;
            PORT1_LATCH          <= PIO_RST_DATA;
            PORT0_BYPASS         <= PIO_RST_BYP;
            DIGITAL_ONLY_PIN_DIG <= 1'b1;
        end else if (CLK_EN) begin
            data0_reg            <= data0_next;
            data1_reg            <= data1_next;
            drv0_reg             <= drv0_next;
            byp0_reg             <= byp0_next;
            ana0_reg             <= ana0_next;
            SFR_RDATA            <= rdata_next;
            SFR_RVALID           <= SFR_REQ.rd;
            PORT0_PAD            <= pad0_next;
            PORT1_LATCH          <= data1_next;
            PORT0_BYPASS         <= byp0_next;                      // [R7]
            DIGITAL_ONLY_PIN_DIG <= 1'b1;                           // [R11]
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    chk_latch_hold: assert property ( // [R1]
        CLK_EN && !SFR_REQ.wr |=> data0_reg == $past(data0_reg))
        else $error("data latch changed without a write");
    chk_byte_write: assert property ( // [R5]
        CLK_EN && wr_byte && hit_d0 |=> data0_reg == $past(SFR_REQ.wdata))
        else $error("byte write not latched");
    chk_bit_write: assert property ( // [R4]
        CLK_EN && wr_bit && hit_b1 |=> data1_reg[$past(bn)] == $past(SFR_REQ.wdata[0]))
        else $error("bit write not latched");
    chk_pin_read: assert property ( // [R2]
        CLK_EN && rd_byte && hit_d1 && !SFR_REQ.rmw |=> SFR_RDATA == $past(pin1_s))
        else $error("plain read did not return pins");
    chk_rmw_read: assert property ( // [R3]
        CLK_EN && rd_byte && hit_d0 && SFR_REQ.rmw |=> SFR_RDATA == $past(data0_reg))
        else $error("rmw read did not return latch");
    chk_analog_off: assert property ( // [R9]
        CLK_EN |=> ((PORT0_PAD.oe | PORT0_PAD.dig) & ~$past(ana0_next)) == 8'h00)
        else $error("analog pin driven or receiving");
    chk_smb_od: assert property ( // [R14]
        (PORT0_PAD.oe & PORT0_PAD.out & $past(PORT0_SMB_PIN) & {8{$past(CLK_EN)}}) == 8'h00)
        else $error("SMBus pin drove high");
    chk_digital_only: assert property ( // [R11]
        DIGITAL_ONLY_PIN_DIG)
        else $error("digital-only pin not digital");
    chk_drv_ignored: assert property ( // [R12] [R13]
        CLK_EN |=> ((PORT0_PAD.oe & PORT0_PAD.out & ~$past(pp)) == 8'h00))
        else $error("high driven without push-pull");
    chk_bypass_out: assert property ( // [R7]
        CLK_EN |=> PORT0_BYPASS == byp0_reg &&
                   ((PORT0_PAD.out ^ data0_reg) & byp0_reg) == 8'h00)
        else $error("bypassed pin not driven from the latch");
    chk_xbar_route: assert property ( // [R7]
        CLK_EN |=> ((PORT0_PAD.out ^ $past(PORT0_XBAR_OUT)) & $past(PORT0_XBAR_EN)
                    & ~byp0_reg) == 8'h00)
        else $error("crossbar pin not driven from the crossbar");

    // Register access beyond the first port data latch
    chk_cfg_write: assert property ( // [R4]
        CLK_EN && wr_byte && hit_drv0 |=> drv0_reg == $past(SFR_REQ.wdata))
        else $error("driver type write not latched");
    chk_bit_read: assert property ( // [R2] [R4]
        CLK_EN && rd_bit && hit_b1 && !SFR_REQ.rmw |=>
            SFR_RDATA == {7'h00, $past(pin1_s[bn])})
        else $error("plain bit read did not return the pin");
    chk_read_pulse: assert property ( // [R2]
        CLK_EN |=> SFR_RVALID == $past(SFR_REQ.rd))
        else $error("read valid not one cycle after the read");
    chk_latch1_hold: assert property ( // [R1] [R6]
        CLK_EN && !SFR_REQ.wr |=> PORT1_LATCH == $past(data1_reg))
        else $error("second port latch changed without a write");

    // Nothing but a reset moves while the clock enable is low
    chk_ce_freeze: assert property ( // [R1]
        !CLK_EN |=> $stable(data0_reg) && $stable(data1_reg) && $stable(PORT0_PAD)
                    && $stable(SFR_RVALID))
        else $error("state moved while clock enable low");

    //------------------------------------------------------------------
    // Coverage
    //------------------------------------------------------------------
    cov_rmw: cover property (CLK_EN && SFR_REQ.rd && SFR_REQ.rmw && hit_d0);
    cov_bitwr: cover property (CLK_EN && wr_bit && hit_b0);
    cov_pp_high: cover property (PORT0_PAD.oe[0] && PORT0_PAD.out[0]);
    cov_ce_low: cover property (!CLK_EN && SFR_REQ.wr);
    cov_analog_pin: cover property (PORT0_PAD.dig != 8'hFF);
endmodule

// File: verif/pio_pins_model.sv
// Pin model for both ports: pads, weak pullups and outside pull-downs.
// Assumes the register bank pad struct and a single clock.
module pio_pins_model (
    input  wire logic              clk,
    input  wire pio_pkg::pio_pad_t pad,
    input  wire logic [7:0]        latch1,
    input  wire logic [7:0]        low0,
    input  wire logic [7:0]        low1,
    output logic [7:0]             pin0,
    output logic [7:0]             pin1
);
    timeunit 1ns;
    timeprecision 1ns;
    import pio_pkg::*;
    logic [7:0] float_q = 8'h55;
    // Undriven analog pins wander so a stale level cannot pass
    always @(posedge clk) begin
        float_q <= ~float_q;
    end
    // Driven pad wins, then outside pull-down, then weak pullup
    assign pin0 = (pad.oe & pad.out) | (~pad.oe & ~low0 & (pad.dig | float_q));
    // Second port pads are open-drain with a pullup
    assign pin1 = latch1 & ~low1;
endmodule

// File: verif/test_port_io_config_regs.sv
// Self-checking bench for the port register bank.
// Assumes the pin model on the far side; one scenario drops CLK_EN.
module test_port_io_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import pio_pkg::*;
    logic       clk, rst, ce, rvalid, dig_only;
    pio_req_t   req;
    pio_pad_t   pad;
    logic [7:0] rdata, pin0, pin1, smb, xen, xout, byp, lat1, low0, low1;
    int         failures = 0;
    int         check_count = 0;
    int         cycles = 0;

    pio_regs u_pio_regs (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .SFR_REQ(req),
        .SFR_RDATA(rdata), .SFR_RVALID(rvalid), .PORT0_PIN_IN(pin0), .PORT1_PIN_IN(pin1),
        .PORT0_SMB_PIN(smb), .PORT0_XBAR_EN(xen), .PORT0_XBAR_OUT(xout), .PORT0_PAD(pad),
        .PORT1_LATCH(lat1), .PORT0_BYPASS(byp), .DIGITAL_ONLY_PIN_DIG(dig_only));
    pio_pins_model u_pio_pins_model (.clk(clk), .pad(pad), .latch1(lat1), .low0(low0),
        .low1(low1), .pin0(pin0), .pin1(pin1));

    //------------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle request, driven just after an edge
    task automatic sfr(input logic w, r, m, b, input logic [7:0] a, d);
        @(posedge clk);
        #1;
        req = '{wr: w, rd: r, rmw: m, bit_op: b, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic m, b, input logic [7:0] exp);
        sfr(1'b0, 1'b1, m, b, a, 8'h00);
        chk(rvalid ? rdata : ~exp, exp);
    endtask
    task automatic wr(input logic [7:0] a, d);
        sfr(1'b1, 1'b0, 1'b0, 1'b0, a, d);
    endtask
    task automatic wrap_up;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic t_reset;
        chk(pad.out, 8'hFF);
        chk(pad.oe, 8'h00);
        chk(pad.dig, 8'hFF);
        chk(byp, 8'h00);
        chk({7'h00, dig_only}, 8'h01);
        rd(PIO_ADR_DRV0, 1'b0, 1'b0, PIO_RST_DRV);
        rd(PIO_ADR_BYP0, 1'b0, 1'b0, PIO_RST_BYP);
        rd(PIO_ADR_ANA0, 1'b0, 1'b0, PIO_RST_ANA);
        rd(PIO_ADR_DATA0, 1'b0, 1'b0, 8'hFF);
        rd(PIO_ADR_DATA1, 1'b0, 1'b0, 8'hFF);
        wr(8'hA5, 8'h3C);
        rd(8'hA5, 1'b0, 1'b0, 8'h00);
    endtask
    task automatic t_latch;
        wr(PIO_ADR_DATA0, 8'h5A);
        chk(pad.out, 8'h5A);
        chk(pad.oe, 8'hA5);
        low0 = 8'h02;
        repeat (3) @(posedge clk);
        rd(PIO_ADR_DATA0, 1'b0, 1'b0, 8'h58);
        rd(PIO_ADR_DATA0, 1'b1, 1'b0, 8'h5A);
        low0 = 8'h00;
    endtask
    task automatic t_bypass;
        wr(PIO_ADR_BYP0, 8'h0F);
        chk(byp, 8'h0F);
        xen = 8'hFF;
        xout = 8'h30;
        @(posedge clk);
        #1;
        chk(pad.out, 8'h3A);
        chk(pad.oe, 8'hC5);
        rd(PIO_ADR_BYP0, 1'b0, 1'b0, 8'h0F);
        xen = 8'h00;
    endtask
    task automatic t_bits;
        sfr(1'b1, 1'b0, 1'b0, 1'b1, 8'h93, 8'h00);
        chk(lat1, 8'hF7);
        sfr(1'b1, 1'b0, 1'b0, 1'b1, 8'h81, 8'h00);
        chk(pad.out, 8'h58);
        rd(8'h93, 1'b1, 1'b1, 8'h00);
        rd(8'h94, 1'b1, 1'b1, 8'h01);
        low1 = 8'h01;
        repeat (3) @(posedge clk);
        rd(PIO_ADR_DATA1, 1'b0, 1'b0, 8'hF6);
        rd(8'h90, 1'b0, 1'b1, 8'h00);
        low1 = 8'h00;
    endtask
    task automatic t_modes;
        wr(PIO_ADR_DRV0, 8'hFF);
        chk(pad.oe, 8'hFF);
        wr(PIO_ADR_ANA0, 8'h0F);
        chk(pad.dig, 8'h0F);
        chk(pad.oe, 8'h0F);
        wr(PIO_ADR_ANA0, 8'hFF);
        smb = 8'h08;
        @(posedge clk);
        #1;
        chk(pad.oe, 8'hF7);
        smb = 8'h00;
    endtask
    // Clock enable low drops a write; a mid-run reset still applies
    task automatic t_freeze;
        ce = 1'b0;
        wr(PIO_ADR_DATA0, 8'h00);
        chk(pad.out, 8'h58);
        ce = 1'b1;
        rd(PIO_ADR_DATA0, 1'b1, 1'b0, 8'h58);
        ce = 1'b0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(pad.out, PIO_RST_DATA);
        chk(pad.oe, 8'h00);
        chk(lat1, PIO_RST_DATA);
        chk(byp, PIO_RST_BYP);
        ce = 1'b1;
        rd(PIO_ADR_DRV0, 1'b0, 1'b0, PIO_RST_DRV);
        rd(PIO_ADR_DATA0, 1'b1, 1'b0, PIO_RST_DATA);
    endtask

    //------------------------------------------------------------------
    // Clock, watchdog and main sequence
    //------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Cut a hang short
    initial begin
        forever @(posedge clk) begin
            cycles++;
            if (cycles > 2000) begin
                failures++;
                wrap_up;
            end
        end
    end
    initial begin
        rst = 1'b1;
        req = '0;
        {smb, xen, xout, low0, low1} = '0;
        ce = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset;
        t_latch;
        t_bypass;
        t_bits;
        t_modes;
        t_freeze;
        wrap_up;
    end
endmodule
